// ### rtl/sew_pkg.sv
package sew_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS   = 100;
    localparam int WAKE_RELEASE_NS = 10000;
    localparam int SLEEP_ENTRY_NS  = 20000;
    localparam int WRITE_CYCLE_NS  = 1000000;

    // least times round up to whole cycles
    localparam int WAKE_RELEASE_CYC = (WAKE_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLEEP_ENTRY_CYC  = (SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYCLE_CYC  = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int DLY_W  = 16;
    localparam int BUSY_W = 24;

    localparam logic [DLY_W-1:0]  WAKE_RELEASE_CNT = DLY_W'(WAKE_RELEASE_CYC);
    localparam logic [DLY_W-1:0]  SLEEP_ENTRY_CNT  = DLY_W'(SLEEP_ENTRY_CYC);
    localparam logic [BUSY_W-1:0] BUSY_ONE         = 24'h000001;

    // ==========================================================
    // serial frame
    localparam int               CNT_W          = 10;
    localparam logic [CNT_W-1:0] CNT_MAX        = 10'h3FF;
    localparam logic [CNT_W-1:0] CMD_BITS       = 10'h008;
    localparam logic [CNT_W-1:0] STATUS_WR_BITS = 10'h010;
    localparam logic [CNT_W-1:0] SIG_START_BITS = 10'h018;
    localparam logic [CNT_W-1:0] WRITE_MIN_BITS = 10'h020;
    localparam logic [2:0]       BYTE_LSBS_ZERO = 3'h0;
    localparam logic [2:0]       SIG_MSB        = 3'h7;
    localparam int               GUARD_BIT      = 7;

    // ==========================================================
    // instruction codes
    localparam logic [7:0] OP_WREN  = 8'h11;
    localparam logic [7:0] OP_WRSR  = 8'h22;
    localparam logic [7:0] OP_WRITE = 8'h33;
    localparam logic [7:0] OP_SLEEP = 8'h44;
    localparam logic [7:0] OP_WAKE  = 8'h55;

    // arbitrary value, not tied to any maker
    localparam logic [7:0] SIGNATURE_DEF = 8'h5A;

    // ==========================================================
    // pin slots in the synchroniser
    localparam int PIN_N    = 5;
    localparam int PIN_CS   = 0;
    localparam int PIN_SCK  = 1;
    localparam int PIN_SI   = 2;
    localparam int PIN_HOLD = 3;
    localparam int PIN_WP   = 4;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_SHIFT  = 4'b0010,
        ST_SIGOUT = 4'b0100,
        ST_IGNORE = 4'b1000
    } sew_state_e;

endpackage : sew_pkg

// ### rtl/sew_if.sv
`timescale 1ns/100ps

interface sew_if #(parameter int N = 1);
    logic [N-1:0] lvl;
    logic [N-1:0] prv;

    modport syncSide (output lvl, output prv);
    modport useSide  (input lvl, input prv);
endinterface : sew_if

// ### rtl/sew_pin_sync.sv
`timescale 1ns/100ps

module sew_pin_sync #(
    parameter int N = 1
)
(
    input  logic         clk_sys,
    input  logic         srst,
    input  logic         ce,
    input  logic [N-1:0] pins,
    sew_if.syncSide      io
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [N-1:0] meta;
        logic [N-1:0] lvl;
        logic [N-1:0] prv;
    } sew_sync_s;

    sew_sync_s r;
    sew_sync_s d;

    // meta feeds lvl only; edges come from lvl against prv
    always_comb
    begin
        d      = r;
        d.meta = pins;
        d.lvl  = r.meta;
        d.prv  = r.lvl;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            r <= '0;
        else if (ce)
            r <= d;
    end

    assign io.lvl = r.lvl;
    assign io.prv = r.prv;

endmodule : sew_pin_sync

// ### rtl/sew_top.sv
`timescale 1ns/100ps

// Function
// - asleep, every instruction except the wake-and-signature command is ignored
// - awake, that command returns the signature unless a write cycle runs
// - after the last dummy bit the eight-bit signature shifts out
// - further clocks repeat the signature until select rises
// - select rise after a signature read returns the part to standby
// - select rise right after the wake command still wakes; standby after delay
// - select low selects; select high deselects and gives standby unless writing, waking or asleep
// - a started write cycle completes regardless of select
// - data output floats while deselected
// - select rise closing a valid write sequence launches the timed write
// - guard pin low with guard enable set refuses status writes
// - guard pin falling after write launch does not disturb it
// - guard enable clear makes the guard pin ignored
// - serial input sampled on serial clock rising edge
// - serial output updated after serial clock falling edge
// - pause low mid-sequence suspends without losing position
// - pause changes take effect only while serial clock is low
// - while paused, serial input and clock are ignored
// - output floats at once on pause fall, drives again on rise
// - sleep entered by sleep command closed with select rise
// - completed byte, page or status write clears the write enable latch
module sew_top #(
    parameter logic [7:0] SIGNATURE    = sew_pkg::SIGNATURE_DEF,
    parameter int         WRITE_CYCLES = sew_pkg::WRITE_CYCLE_CYC
)
(
    input  logic clk_sys,
    input  logic srst,
    input  logic ce,
    input  logic csN,
    input  logic sck,
    input  logic si,
    input  logic holdN,
    input  logic wpN,
    output logic soOut,
    output logic soOe,
    output logic busy,
    output logic writeEnableLatch,
    output logic writeGuardEnableBit,
    output logic asleep,
    output logic lowPower,
    output logic standby
);
    import sew_pkg::*;

    // ==========================================================
    // pin synchronisers
    sew_if #(.N(PIN_N)) pinIf ();

    sew_pin_sync #(
        .N       (PIN_N)
    ) uSync (
        .clk_sys (clk_sys),
        .srst    (srst),
        .ce      (ce),
        .pins    ({wpN, holdN, si, sck, csN}),
        .io      (pinIf.syncSide)
    );

    logic csLvl;
    logic csRise;
    logic csFall;
    logic sckLvl;
    logic sckRise;
    logic sckFall;
    logic siLvl;
    logic holdLvl;
    logic wpLvl;
    logic wantPause;
    logic [7:0] cmdNext;

    assign csLvl   = pinIf.lvl[PIN_CS];
    assign csRise  = pinIf.lvl[PIN_CS] & ~pinIf.prv[PIN_CS];
    assign csFall  = ~pinIf.lvl[PIN_CS] & pinIf.prv[PIN_CS];
    assign sckLvl  = pinIf.lvl[PIN_SCK];
    assign sckRise = pinIf.lvl[PIN_SCK] & ~pinIf.prv[PIN_SCK];
    assign sckFall = ~pinIf.lvl[PIN_SCK] & pinIf.prv[PIN_SCK];
    assign siLvl   = pinIf.lvl[PIN_SI];
    assign holdLvl = pinIf.lvl[PIN_HOLD];
    assign wpLvl   = pinIf.lvl[PIN_WP];

    // ==========================================================
    // state
    typedef struct packed {
        sew_state_e        st;
        logic [CNT_W-1:0]  cnt;
        logic [7:0]        shiftIn;
        logic [7:0]        cmd;
        logic [2:0]        sigIdx;
        logic              sel;
        logic              paused;
        logic              soLive;
        logic              asleep;
        logic              waking;
        logic              wrLatch;
        logic              guardEn;
        logic              wip;
        logic [DLY_W-1:0]  dlyCnt;
        logic [BUSY_W-1:0] busyCnt;
        logic              soOut;
        logic              soOe;
        logic              standby;
        logic              lowPower;
    } sew_reg_s;

    localparam sew_reg_s REG_RST = '{
        st:       ST_IDLE,
        cnt:      '0,
        shiftIn:  '0,
        cmd:      '0,
        sigIdx:   '0,
        sel:      1'b0,
        paused:   1'b0,
        soLive:   1'b0,
        asleep:   1'b0,
        waking:   1'b0,
        wrLatch:  1'b0,
        guardEn:  1'b0,
        wip:      1'b0,
        dlyCnt:   '0,
        busyCnt:  '0,
        soOut:    1'b0,
        soOe:     1'b0,
        standby:  1'b1,
        lowPower: 1'b0
    };

    sew_reg_s r;
    sew_reg_s d;

    assign wantPause = r.sel && (r.cnt != '0) && !holdLvl;
    assign cmdNext   = {r.shiftIn[6:0], siLvl};

    // ==========================================================
    // next state
    always_comb
    begin
        d = r;

        // pause only switches with the clock low; a high clock defers it to the fall
        if (!sckLvl)
            d.paused = wantPause;

        if (r.dlyCnt != '0)
            d.dlyCnt = r.dlyCnt - 1'b1;
        if (r.dlyCnt == '0)
            d.waking = 1'b0;

        // the timed write ignores select entirely
        if (r.wip)
        begin
            d.busyCnt = r.busyCnt - 1'b1;
            if (r.busyCnt == BUSY_ONE)
            begin
                d.wip = 1'b0;
                d.wrLatch = 1'b0;
            end
        end

        if (csFall)
        begin
            d.sel    = 1'b1;
            d.st     = ST_SHIFT;
            d.cnt    = '0;
            d.cmd    = '0;
            d.soLive = 1'b0;
        end
        else if (csRise)
        begin
            d.sel    = 1'b0;
            d.st     = ST_IDLE;
            d.paused = 1'b0;
            d.cnt    = '0;
            d.soLive = 1'b0;
            if (r.asleep)
            begin
                // only the wake command counts, even cut short after its code
                if (r.cmd == OP_WAKE && r.cnt >= CMD_BITS)
                begin
                    d.asleep = 1'b0;
                    d.waking = 1'b1;
                    d.dlyCnt = WAKE_RELEASE_CNT;
                end
            end
            else if (!r.wip && r.cmd == OP_SLEEP && r.cnt == CMD_BITS)
            begin
                d.asleep = 1'b1;
                d.dlyCnt = SLEEP_ENTRY_CNT;
            end
            else if (!r.wip && r.cmd == OP_WREN && r.cnt == CMD_BITS)
                d.wrLatch = 1'b1;
            else if (!r.wip && r.wrLatch && r.cmd == OP_WRSR && r.cnt == STATUS_WR_BITS)
            begin
                // guard pin is looked at only here, so a later fall cannot hurt
                if (!(r.guardEn && !wpLvl))
                begin
                    d.guardEn = r.shiftIn[GUARD_BIT];
                    d.wip     = 1'b1;
                    d.busyCnt = BUSY_W'(WRITE_CYCLES);
                end
            end
            else if (!r.wip && r.wrLatch && r.cmd == OP_WRITE && r.cnt >= WRITE_MIN_BITS
                     && r.cnt[2:0] == BYTE_LSBS_ZERO)
            begin
                d.wip     = 1'b1;
                d.busyCnt = BUSY_W'(WRITE_CYCLES);
            end
        end
        else if (r.sel && !r.paused)
        begin
            if (sckRise)
            begin
                d.shiftIn = cmdNext;
                if (r.cnt != CNT_MAX)
                    d.cnt = r.cnt + 1'b1;
            end
            unique case (r.st)
                ST_IDLE:
                begin
                end
                ST_SHIFT:
                begin
                    if (sckRise && r.cnt == CMD_BITS - 1'b1)
                    begin
                        d.cmd = cmdNext;
                        if ((r.asleep && cmdNext != OP_WAKE) || (cmdNext == OP_WAKE && r.wip))
                            d.st = ST_IGNORE;
                    end
                    if (sckRise && r.cmd == OP_WAKE && r.cnt == SIG_START_BITS - 1'b1)
                    begin
                        d.st     = ST_SIGOUT;
                        d.sigIdx = SIG_MSB;
                    end
                end
                ST_SIGOUT:
                begin
                    if (sckFall)
                    begin
                        d.soOut  = SIGNATURE[r.sigIdx];
                        d.soLive = 1'b1;
                        d.sigIdx = r.sigIdx - 1'b1;
                    end
                end
                ST_IGNORE:
                begin
                end
                default:
                    d.st = ST_IDLE;
            endcase
        end

        // output enable follows the pause pin level, not the deferred pause state
        d.soOe     = d.sel && d.soLive && (d.st == ST_SIGOUT) && holdLvl;
        d.standby  = !d.sel && !d.wip && !d.waking && !d.asleep;
        d.lowPower = d.asleep && (d.dlyCnt == '0);
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            r <= REG_RST;
        else if (ce)
            r <= d;
    end

    assign soOut               = r.soOut;
    assign soOe                = r.soOe;
    assign busy                = r.wip;
    assign writeEnableLatch    = r.wrLatch;
    assign writeGuardEnableBit = r.guardEn;
    assign asleep              = r.asleep;
    assign lowPower            = r.lowPower;
    assign standby             = r.standby;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_last_dummy;
        ce && sckRise && !csRise && !csFall && r.sel && !r.paused
        && r.st == ST_SHIFT && r.cmd == OP_WAKE && r.cnt == SIG_START_BITS - 1'b1;
    endsequence

    sequence s_wake;
        $fell(r.asleep) ##0 (r.waking && r.dlyCnt == WAKE_RELEASE_CNT);
    endsequence

    a_float_desel: assert property (!r.sel |-> !r.soOe)
        else $error("output driven while deselected");

    a_hold_float: assert property ((ce && !holdLvl) |=> !r.soOe)
        else $error("output driven while pause low");

    a_sleep_ignore: assert property ((ce && r.asleep && !r.wip) |=> !r.wip)
        else $error("write launched while asleep");

    a_busy_no_sig: assert property (r.wip |-> r.st != ST_SIGOUT)
        else $error("signature sent during write cycle");

    a_sig_start: assert property (s_last_dummy |=> r.st == ST_SIGOUT && r.sigIdx == SIG_MSB)
        else $error("signature did not start after dummy address");

    a_sig_repeat: assert property ((ce && sckFall && !csRise && r.sel && !r.paused
        && r.st == ST_SIGOUT && r.sigIdx == '0) |=> r.sigIdx == SIG_MSB)
        else $error("signature did not wrap");

    a_wip_hold: assert property ((ce && r.wip && r.busyCnt > BUSY_ONE) |=> r.wip)
        else $error("write cycle cut short");

    a_guard_refuse: assert property ((ce && csRise && !r.asleep && !r.wip && r.guardEn
        && !wpLvl && r.cmd == OP_WRSR) |=> r.guardEn && !r.wip)
        else $error("guarded status write accepted");

    a_guard_off: assert property ((ce && csRise && !r.asleep && !r.wip && r.wrLatch && !r.guardEn
        && r.cmd == OP_WRSR && r.cnt == STATUS_WR_BITS) |=> r.wip)
        else $error("unguarded status write refused");

    a_latch_clear: assert property ($fell(r.wip) |-> !r.wrLatch)
        else $error("write enable latch kept after write");

    a_sample_rise: assert property ((ce && sckRise && !csRise && !csFall && r.sel && !r.paused
        && r.cnt < CNT_MAX) |=> r.cnt == $past(r.cnt) + 10'h001)
        else $error("rising edge not counted");

    a_so_fall: assert property ($changed(r.soOut) |-> $past(sckFall))
        else $error("output changed without falling edge");

    a_pause_hold: assert property ((ce && r.paused && !csRise && !csFall)
        |=> $stable(r.cnt) && $stable(r.shiftIn))
        else $error("activity taken while paused");

    a_pause_defer: assert property ((ce && sckLvl && !csRise) |=> $stable(r.paused))
        else $error("pause changed with clock high");

    a_sleep_entry: assert property ($rose(r.asleep) |-> $past(csRise))
        else $error("sleep entered without select rise");

    a_wake_delay: assert property ($fell(r.asleep) |-> s_wake)
        else $error("wake without release delay");

    a_cs_desel: assert property ((ce && csRise) |=> !r.sel && !r.soOe)
        else $error("select rise did not deselect");

endmodule : sew_top

// ### verif/sew_host_model.sv
`timescale 1ns/100ps

module sew_host_model
(
    input  logic clk_sys,
    input  logic soOut,
    input  logic soOe,
    output logic csN,
    output logic sck,
    output logic si,
    output logic holdN
);

    // ==========================================================
    // idle levels: deselected, link clock parked low
    initial
    begin
        csN   = 1'b1;
        sck   = 1'b0;
        si    = 1'b0;
        holdN = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_clk

    // ==========================================================
    // one framed transfer, 800 ns link period, bits left aligned
    task automatic xfer(input  logic [31:0] tx,
                        input  int          nTx,
                        input  int          nRx,
                        input  int          pauseAt,
                        output logic [15:0] rx,
                        output logic [15:0] oeSeen,
                        output logic        pausedOe);
        int i;
        logic siKeep;
        rx       = 16'h0000;
        oeSeen   = 16'h0000;
        pausedOe = 1'b1;
        csN      = 1'b0;
        wait_clk(4);
        for (i = 0; i < nTx + nRx; i++)
        begin
            sck = 1'b0;
            // past the nTx sent bits the line carries a changing pattern
            si = (i < nTx) ? tx[31-i] : ~si;
            wait_clk(4);
            if (i == pauseAt)
            begin
                siKeep = si;
                holdN = 1'b0;
                wait_clk(4);
                pausedOe = soOe;
                // stray clock and data while paused must be ignored
                sck = 1'b1;
                si = ~si;
                wait_clk(4);
                // released with the clock high, so leaving waits for its fall
                holdN = 1'b1;
                wait_clk(4);
                sck = 1'b0;
                // the pending bit must be back before the next rise
                si = siKeep;
                wait_clk(4);
            end
            sck = 1'b1;
            wait_clk(4);
            if (i >= nTx)
            begin
                rx = {rx[14:0], soOut};
                oeSeen = {oeSeen[14:0], soOe};
            end
        end
        sck = 1'b0;
        wait_clk(4);
        csN = 1'b1;
        si = ~si;
        wait_clk(8);
    endtask : xfer

endmodule : sew_host_model

// ### verif/sew_top_tb_top.sv
`timescale 1ns/100ps

module sew_top_tb_top;
    import sew_pkg::*;

    // arbitrary value, not tied to any maker
    localparam logic [7:0] SIG    = 8'h96;
    // long enough to span a whole frame issued during the write
    localparam int         WR_CYC = 400;

    logic        clk_sys;
    logic        srst;
    logic        ce;
    logic        csN;
    logic        sck;
    logic        si;
    logic        holdN;
    logic        wpN;
    logic        soOut;
    logic        soOe;
    logic        busy;
    logic        writeEnableLatch;
    logic        writeGuardEnableBit;
    logic        asleep;
    logic        lowPower;
    logic        standby;
    logic [15:0] rx;
    logic [15:0] oeSeen;
    logic        pausedOe;
    int          n_errors;
    int          n_checks;
    int          cycles = 0;

    sew_top #(
        .SIGNATURE    (SIG),
        .WRITE_CYCLES (WR_CYC)
    ) sew_top_i (
        .clk_sys             (clk_sys),
        .srst                (srst),
        .ce                  (ce),
        .csN                 (csN),
        .sck                 (sck),
        .si                  (si),
        .holdN               (holdN),
        .wpN                 (wpN),
        .soOut               (soOut),
        .soOe                (soOe),
        .busy                (busy),
        .writeEnableLatch    (writeEnableLatch),
        .writeGuardEnableBit (writeGuardEnableBit),
        .asleep              (asleep),
        .lowPower            (lowPower),
        .standby             (standby)
    );

    sew_host_model sew_host_model_i (
        .clk_sys (clk_sys),
        .soOut   (soOut),
        .soOe    (soOe),
        .csN     (csN),
        .sck     (sck),
        .si      (si),
        .holdN   (holdN)
    );

    // ==========================================================
    // clock and timeout
    initial
    begin
        clk_sys = 1'b0;
    end

    always #50 clk_sys = ~clk_sys;

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            n_errors++;
            complete_run();
        end
    end

    // ==========================================================
    // helpers
    task automatic complete_run();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chkb(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask : chkb

    task automatic run(input logic [31:0] tx, input int nTx, input int nRx, input int pauseAt);
        sew_host_model_i.xfer(tx, nTx, nRx, pauseAt, rx, oeSeen, pausedOe);
    endtask : run

    task automatic wait_idle();
        int n;
        for (n = 0; n < 1000 && busy !== 1'b0; n++)
            @(negedge clk_sys);
    endtask : wait_idle

    // ==========================================================
    // scenarios
    task automatic t_reset();
        chkb(standby, 1'b1);
        chkb(soOe, 1'b0);
        chkb(asleep, 1'b0);
    endtask : t_reset

    task automatic t_signature();
        run({OP_WAKE, 16'hA5C3, 8'h00}, 24, 16, -1);
        chk(rx, {SIG, SIG});
        chk(oeSeen, 16'hFFFF);
        chkb(soOe, 1'b0);
        chkb(standby, 1'b1);
    endtask : t_signature

    task automatic t_sleep_wake();
        int k;
        for (k = 0; k < 2; k++)
        begin
            run({OP_SLEEP, 24'h000000}, 8, 0, -1);
            chkb(asleep, 1'b1);
            chkb(lowPower, 1'b0);
            sew_host_model_i.wait_clk(SLEEP_ENTRY_CYC + 8);
            chkb(lowPower, 1'b1);
            run({OP_WREN, 24'h000000}, 8, 0, -1);
            chkb(writeEnableLatch, 1'b0);
            if (k == 0)
                run({OP_WAKE, 24'h000000}, 8, 0, -1);
            else
                run({OP_WAKE, 16'h0F0F, 8'h00}, 24, 16, -1);
            if (k == 1)
                chk(rx, {SIG, SIG});
            chkb(asleep, 1'b0);
            chkb(standby, 1'b0);
            sew_host_model_i.wait_clk(WAKE_RELEASE_CYC);
            chkb(standby, 1'b1);
        end
    endtask : t_sleep_wake

    task automatic t_write();
        run({OP_WREN, 24'h000000}, 8, 0, -1);
        chkb(writeEnableLatch, 1'b1);
        run({OP_WRITE, 16'h0100, 8'h3C}, 32, 0, -1);
        chkb(busy, 1'b1);
        chkb(standby, 1'b0);
        wpN = 1'b0;
        run({OP_WAKE, 16'h0000, 8'h00}, 24, 16, -1);
        chk(oeSeen, 16'h0000);
        chkb(busy, 1'b1);
        wait_idle();
        chkb(busy, 1'b0);
        chkb(writeEnableLatch, 1'b0);
        chkb(standby, 1'b1);
        wpN = 1'b1;
    endtask : t_write

    task automatic t_guard();
        logic [4:0] wpTab;
        logic [4:0] gTab;
        logic [4:0] eTab;
        int         i;
        wpTab = 5'b10101;
        gTab  = 5'b01001;
        eTab  = 5'b01011;
        for (i = 0; i < 5; i++)
        begin
            wpN = wpTab[i];
            run({OP_WREN, 24'h000000}, 8, 0, -1);
            run({OP_WRSR, gTab[i], 7'h00, 16'h0000}, 16, 0, -1);
            wait_idle();
            chkb(writeGuardEnableBit, eTab[i]);
        end
        wpN = 1'b1;
    endtask : t_guard

    task automatic t_freeze();
        // a frame sent with the enable low must leave no trace
        ce = 1'b0;
        run({OP_WREN, 24'h000000}, 8, 0, -1);
        ce = 1'b1;
        chkb(writeEnableLatch, 1'b0);
        run({OP_WREN, 24'h000000}, 8, 0, -1);
        chkb(writeEnableLatch, 1'b1);
    endtask : t_freeze

    task automatic t_pause();
        int k;
        for (k = 0; k < 2; k++)
        begin
            run({OP_WAKE, 16'h3C3C, 8'h00}, 24, 16, (k == 0) ? 5 : 27);
            chk(rx, {SIG, SIG});
            chkb(pausedOe, 1'b0);
            chk(oeSeen, 16'hFFFF);
        end
    endtask : t_pause

    // ==========================================================
    // main sequence
    initial
    begin
        n_errors = 0;
        n_checks = 0;
        srst     = 1'b1;
        ce       = 1'b1;
        wpN      = 1'b1;
        repeat (5) @(negedge clk_sys);
        srst = 1'b0;
        repeat (2) @(negedge clk_sys);
        t_reset();
        t_signature();
        t_sleep_wake();
        t_write();
        t_guard();
        t_freeze();
        t_pause();
        complete_run();
    end

endmodule : sew_top_tb_top
